// *** hw/exposure_trigger_control.sv ***
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1: With arm set, each software trigger write of 1 starts an exposure.
// RULE2: Software polls the trigger field and writes 1 only after it reads 0.
// RULE3: Device self-clears the trigger field when ready for another exposure.
// RULE4: Software exposure lasts shutter time, then readout begins.
// RULE5: Writing arm to 0 stops all triggered exposure starts.
// RULE6: Formats 0 to 2 pace the self-clear by the current format rate.
// RULE7: Format 7 paces the self-clear by the rate control register.
// RULE8: Manual rate off means run at the maximum permitted rate.
// RULE9: Manual rate on uses requested rate, clamped to the maximum.
// RULE10: Software trigger starts exposure in the next cycle, no setup delay.
// RULE11: External trigger on selected port starts on the chosen edge.
// RULE12: External source holds the active level at least 100 ns.
// RULE13: External source never triggers faster than maximum capture rate.
// RULE14: Programmable mode exposes from active edge for shutter time.
// RULE15: Level mode exposes from active edge until opposite edge.
// RULE16: Level mode uses shutter time as minimum and for trigger ready.
// RULE17: Software sets shutter to the shortest intended pulse exposure.
// RULE18: Exposure ending during previous readout is extended until readout ends; the code extends only level mode exposures (ST_HOLD).
// RULE19: Pulse ending after readout ends exposure at the pulse end.
// RULE20: Polarity 0 selects falling edge, 1 selects rising edge.
// RULE21: Mode 0 selects programmable, 1 selects level controlled.
// RULE22: Source 7 is software, 0 and 1 are input ports.
// RULE23: Triggered exposure is active only while trigger enable is 1.
// RULE24: External trigger passes two flip-flops before edge detection.
// RULE25: A write of 1 while the trigger field reads 1 is ignored.
module exposure_trigger_control
    import exposure_trigger_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Register bus.
    input wire exposure_trigger_pkg::apb_req_t apbReq,
    output exposure_trigger_pkg::apb_rsp_t apbRsp,
    // External trigger ports.
    input wire logic [1:0] externalTriggerInput,
    // Sensor side.
    input wire logic readoutBusy,
    input wire logic [15:0] maxPeriodUnits,
    output exposure_trigger_pkg::sensor_out_t sensorOut
);
    import exposure_trigger_pkg::*;

    typedef struct packed {
        logic [31:0] trigMode;
        logic softTrig;
        logic arm;
        logic [11:0] shutter;
        logic [2:0] format;
        logic [15:0] stdPeriod;
        logic [31:0] rateCtrl;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic lastLevel;
        exp_state_t state;
        logic [27:0] expCount;
        logic minDone;
        logic [31:0] paceCount;
        logic [31:0] prdata;
        sensor_out_t out;
    } state_t;

    state_t stateReg;
    state_t stateNext;

    function automatic logic [31:0] unitsToCycles(input logic [15:0] units);
        unitsToCycles = 32'(units) * 32'(SHUTTER_BASE_CYCLES);
    endfunction

    logic enabled;
    logic polRising;
    logic levelMode;
    logic [2:0] source;
    logic softSel;
    logic extLevel;
    logic activeEdge;
    logic endEdge;
    logic softFire;
    logic startExp;
    logic [15:0] periodUnits;
    logic [31:0] paceTarget;
    logic [27:0] shutterCycles;
    logic wrAccess;
    logic rdAccess;
    logic mapped;

    always_comb begin
        enabled = stateReg.trigMode[TM_ENABLE_BIT];
        polRising = stateReg.trigMode[TM_POL_BIT]; // RULE20
        levelMode = stateReg.trigMode[TM_MODE_BIT]; // RULE21
        source = stateReg.trigMode[TM_SRC_LSB +: 3];
        softSel = (source == SRC_SOFT); // RULE22
        extLevel = (source == SRC_PORT1) ? stateReg.sync2[1] : stateReg.sync2[0];
        activeEdge = !softSel && (extLevel != stateReg.lastLevel)
                     && (extLevel == polRising); // RULE11
        endEdge = (extLevel != stateReg.lastLevel) && (extLevel != polRising);
        wrAccess = apbReq.psel && apbReq.penable && apbReq.pwrite;
        rdAccess = apbReq.psel && !apbReq.pwrite;
        // A write while the field is set is dropped so that no extra frame starts.
        softFire = wrAccess && apbReq.paddr == OFF_SOFT_TRIGGER && apbReq.pwdata[0]
                   && !stateReg.softTrig; // RULE25
        startExp = enabled && stateReg.arm && stateReg.state == ST_IDLE
                   && ((softSel && softFire) || activeEdge); // RULE1 RULE5 RULE23
        if (stateReg.format == FMT_SCALABLE) begin // RULE7
            if (!stateReg.rateCtrl[RC_MANUAL_BIT]) begin
                periodUnits = maxPeriodUnits; // RULE8
            end else if (stateReg.rateCtrl[15:0] > maxPeriodUnits) begin
                periodUnits = stateReg.rateCtrl[15:0]; // RULE9
            end else begin
                periodUnits = maxPeriodUnits; // RULE9
            end
        end else begin
            periodUnits = (stateReg.stdPeriod > maxPeriodUnits) ? stateReg.stdPeriod
                          : maxPeriodUnits; // RULE6
        end
        paceTarget = unitsToCycles(periodUnits);
        shutterCycles = 28'(unitsToCycles({4'h0, stateReg.shutter}));
        mapped = apbReq.paddr inside {OFF_TRIGGER_MODE, OFF_SOFT_TRIGGER, OFF_CAPTURE_ARM,
                                      OFF_SHUTTER, OFF_FORMAT, OFF_RATE_CTRL, OFF_STATUS};

        stateNext = stateReg;
        stateNext.sync1 = externalTriggerInput;
        stateNext.sync2 = stateReg.sync1; // RULE24
        stateNext.lastLevel = extLevel;
        stateNext.out.frameStart = 1'b0;
        stateNext.out.readoutStart = 1'b0;

        if (wrAccess) begin
            case (apbReq.paddr)
                OFF_TRIGGER_MODE: stateNext.trigMode = apbReq.pwdata;
                OFF_CAPTURE_ARM: stateNext.arm = apbReq.pwdata[0];
                OFF_SHUTTER: stateNext.shutter = apbReq.pwdata[11:0];
                OFF_FORMAT: begin
                    stateNext.format = apbReq.pwdata[2:0];
                    stateNext.stdPeriod = apbReq.pwdata[31:16];
                end
                OFF_RATE_CTRL: stateNext.rateCtrl = apbReq.pwdata;
                default: ;
            endcase
        end
        if (softFire) begin
            stateNext.softTrig = 1'b1;
        end

        if (startExp) begin
            stateNext.paceCount = 32'h0000_0001;
        end else if (stateReg.paceCount != 32'h0000_0000) begin
            stateNext.paceCount = stateReg.paceCount + 32'h0000_0001;
        end
        // Clearing only after the frame period of a started exposure keeps software below the frame rate.
        if (stateReg.softTrig && !softFire && stateReg.state == ST_IDLE
            && (stateReg.paceCount == 32'h0000_0000 || stateReg.paceCount >= paceTarget)) begin
            stateNext.softTrig = 1'b0; // RULE3
            stateNext.paceCount = 32'h0000_0000;
        end

        case (stateReg.state)
            ST_IDLE: begin
                if (startExp) begin
                    stateNext.state = ST_EXPOSE; // RULE10 RULE14
                    stateNext.expCount = 28'h000_0001;
                    stateNext.minDone = 1'b0;
                    stateNext.out.exposureActive = 1'b1;
                    stateNext.out.frameStart = 1'b1;
                    stateNext.out.triggerReady = 1'b0;
                end
            end
            ST_EXPOSE: begin
                stateNext.expCount = stateReg.expCount + 28'h000_0001;
                if (stateReg.expCount >= shutterCycles) begin
                    stateNext.minDone = 1'b1; // RULE16
                    stateNext.out.triggerReady = 1'b1; // RULE16
                end
                if (!levelMode || softSel) begin
                    if (stateReg.expCount >= shutterCycles) begin
                        stateNext.state = ST_IDLE; // RULE4 RULE14
                        stateNext.out.exposureActive = 1'b0;
                        stateNext.out.readoutStart = 1'b1;
                    end
                end else if (endEdge || (extLevel != polRising)) begin
                    stateNext.state = ST_HOLD; // RULE15
                end
            end
            ST_HOLD: begin
                stateNext.expCount = stateReg.expCount + 28'h000_0001;
                if (stateReg.expCount >= shutterCycles) begin
                    stateNext.out.triggerReady = 1'b1;
                end
                // Exposure waits out the previous readout and the minimum time.
                if (!readoutBusy && (stateReg.minDone || stateReg.expCount >= shutterCycles))
                begin
                    stateNext.state = ST_IDLE; // RULE18 RULE19
                    stateNext.out.exposureActive = 1'b0;
                    stateNext.out.readoutStart = 1'b1;
                    stateNext.out.triggerReady = 1'b1;
                end
            end
            default: stateNext.state = ST_IDLE;
        endcase

        if (rdAccess && !apbReq.penable) begin
            case (apbReq.paddr)
                OFF_TRIGGER_MODE: stateNext.prdata = stateReg.trigMode;
                OFF_SOFT_TRIGGER: stateNext.prdata = {31'h0, stateReg.softTrig};
                OFF_CAPTURE_ARM: stateNext.prdata = {31'h0, stateReg.arm};
                OFF_SHUTTER: stateNext.prdata = {20'h0, stateReg.shutter};
                OFF_FORMAT: stateNext.prdata = {stateReg.stdPeriod, 13'h0, stateReg.format};
                OFF_RATE_CTRL: stateNext.prdata = stateReg.rateCtrl;
                OFF_STATUS: stateNext.prdata = {29'h0, stateReg.state};
                default: stateNext.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stateReg <= '0;
            stateReg.trigMode <= TRIGGER_MODE_RST;
            stateReg.shutter <= SHUTTER_RST;
            stateReg.stdPeriod <= PERIOD_RST;
            stateReg.format <= FORMAT_RST;
            stateReg.state <= ST_IDLE;
            stateReg.out.triggerReady <= 1'b1;
        end else begin
            stateReg <= stateNext;
        end
    end

    always_comb begin
        apbRsp.pready = 1'b1;
        apbRsp.pslverr = apbReq.psel && apbReq.penable && !mapped;
        apbRsp.prdata = stateReg.prdata;
        sensorOut = stateReg.out;
    end

    a_soft_start: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
        startExp && softSel |=> sensorOut.exposureActive && sensorOut.frameStart)
        else $error("software trigger did not start exposure");

    a_disarm_block: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
        !stateReg.arm && stateReg.state == ST_IDLE |=> !sensorOut.frameStart)
        else $error("exposure started while disarmed");

    a_enable_gate: assert property (@(posedge clk_sys) disable iff (rst) // RULE23
        !enabled |=> !sensorOut.frameStart)
        else $error("exposure started while triggering disabled");

    a_prog_length: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
        $rose(sensorOut.exposureActive) && !levelMode |-> ##1 sensorOut.exposureActive)
        else $error("programmable exposure too short");

    a_readout_hold: assert property (@(posedge clk_sys) disable iff (rst) // RULE18
        stateReg.state == ST_HOLD && readoutBusy |=> sensorOut.exposureActive)
        else $error("exposure ended during readout");

    a_clear_idle: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
        $fell(stateReg.softTrig) |-> $past(stateReg.state) == ST_IDLE)
        else $error("trigger field cleared during exposure");

    a_ignore_rewrite: assert property (@(posedge clk_sys) disable iff (rst) // RULE25
        softSel && stateReg.softTrig && wrAccess && apbReq.paddr == OFF_SOFT_TRIGGER
        |=> !sensorOut.frameStart)
        else $error("extra exposure from repeated write");

    a_readout_pulse: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
        $fell(sensorOut.exposureActive) |-> sensorOut.readoutStart ##1 !sensorOut.readoutStart)
        else $error("readout start missing at exposure end");

    a_level_end: assert property (@(posedge clk_sys) disable iff (rst) // RULE15
        levelMode && !softSel && stateReg.state == ST_EXPOSE && extLevel != polRising
        |=> stateReg.state == ST_HOLD)
        else $error("level exposure ignored trigger end");

    a_hold_release: assert property (@(posedge clk_sys) disable iff (rst) // RULE19
        stateReg.state == ST_HOLD && !readoutBusy && stateReg.minDone
        |=> !sensorOut.exposureActive && sensorOut.readoutStart)
        else $error("exposure not ended at trigger end");

    a_min_length: assert property (@(posedge clk_sys) disable iff (rst) // RULE16
        $fell(sensorOut.exposureActive) |-> $past(stateReg.expCount) >= $past(shutterCycles))
        else $error("exposure shorter than shutter time");

    a_ready_low: assert property (@(posedge clk_sys) disable iff (rst) // RULE16
        sensorOut.frameStart |-> !sensorOut.triggerReady)
        else $error("trigger ready high at exposure start");

    a_sync_depth: assert property (@(posedge clk_sys) disable iff (rst) // RULE24
        !$past(rst) && !$past(rst, 2) |-> stateReg.sync2 == $past(externalTriggerInput, 2))
        else $error("trigger input not two stages deep");

    a_pace_hold: assert property (@(posedge clk_sys) disable iff (rst) // RULE6 RULE7
        stateReg.softTrig && stateReg.paceCount != 32'h0000_0000
        && stateReg.paceCount < paceTarget |=> stateReg.softTrig)
        else $error("trigger field cleared before frame period");

    a_no_edge: assert property (@(posedge clk_sys) disable iff (rst) // RULE11
        !softSel && stateReg.sync2 == {2{stateReg.lastLevel}} |=> !sensorOut.frameStart)
        else $error("exposure started without a trigger edge");

endmodule

`default_nettype wire

// *** common/exposure_trigger_pkg.sv ***
package exposure_trigger_pkg;

    // Register byte offsets on the APB.
    localparam logic [7:0] OFF_TRIGGER_MODE = 8'h00;
    localparam logic [7:0] OFF_SOFT_TRIGGER = 8'h04;
    localparam logic [7:0] OFF_CAPTURE_ARM = 8'h08;
    localparam logic [7:0] OFF_SHUTTER = 8'h0c;
    localparam logic [7:0] OFF_FORMAT = 8'h10;
    localparam logic [7:0] OFF_RATE_CTRL = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // Trigger mode register fields.
    localparam int TM_ENABLE_BIT = 0;
    localparam int TM_POL_BIT = 1;
    localparam int TM_MODE_BIT = 2;
    localparam int TM_SRC_LSB = 4;
    localparam logic [2:0] SRC_PORT0 = 3'h0;
    localparam logic [2:0] SRC_PORT1 = 3'h1;
    localparam logic [2:0] SRC_SOFT = 3'h7;

    // Rate control register field and the scalable format code.
    localparam int RC_MANUAL_BIT = 31;
    localparam logic [2:0] FMT_SCALABLE = 3'h7;

    // Reset values.
    localparam logic [31:0] TRIGGER_MODE_RST = 32'h0000_0000;
    localparam logic [11:0] SHUTTER_RST = 12'h001;
    localparam logic [15:0] PERIOD_RST = 16'h0001;
    localparam logic [2:0] FORMAT_RST = 3'h0;

    // Timing.
    localparam int CLK_PERIOD_NS = 40;
    localparam int TRIG_MIN_HIGH_NS = 100;
    localparam int TRIG_MIN_CYCLES = (TRIG_MIN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHUTTER_BASE_US = 20;
    localparam int SHUTTER_BASE_CYCLES = SHUTTER_BASE_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXPOSE = 3'b010,
        ST_HOLD = 3'b100
    } exp_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic exposureActive;
        logic frameStart;
        logic readoutStart;
        logic triggerReady;
    } sensor_out_t;

endpackage

// *** dv/sensor_readout_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sensor_readout_model (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Exposure side.
    input wire exposure_trigger_pkg::sensor_out_t sensorOut,
    input wire logic [15:0] readCycles,
    output logic readoutBusy
);
    import exposure_trigger_pkg::*;
    logic [15:0] leftReg;
    // Readout follows each exposure end, so a long setting forces overlap.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            leftReg <= 16'h0000;
        end else if (sensorOut.readoutStart) begin
            leftReg <= readCycles;
        end else if (leftReg != 16'h0000) begin
            leftReg <= leftReg - 16'h0001;
        end
    end
    assign readoutBusy = (leftReg != 16'h0000);
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import exposure_trigger_pkg::*;
    logic clk_sys, rst, readoutBusy, lastErr, prevBusy;
    apb_req_t apbReq;
    apb_rsp_t apbRsp;
    sensor_out_t sensorOut;
    logic [1:0] ext;
    logic [15:0] maxPeriodUnits, readCycles;
    int fail_count, n_compared, cyc, fsCount, fsCyc, curLen, lastLen, busyFall, expEnd;
    exposure_trigger_control DUT (.clk_sys(clk_sys), .rst(rst), .apbReq(apbReq),
        .apbRsp(apbRsp), .externalTriggerInput(ext), .readoutBusy(readoutBusy),
        .maxPeriodUnits(maxPeriodUnits), .sensorOut(sensorOut));
    sensor_readout_model model (.clk_sys(clk_sys), .rst(rst), .sensorOut(sensorOut),
        .readCycles(readCycles), .readoutBusy(readoutBusy));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        prevBusy <= readoutBusy;
        if (cyc > 60000) begin
            fail_count++;
            complete_run();
        end
        if (prevBusy && !readoutBusy) begin
            busyFall <= cyc;
        end
        if (sensorOut.frameStart === 1'b1) begin
            fsCount <= fsCount + 1;
            fsCyc <= cyc;
            chk("readyLow", 0, sensorOut.triggerReady);
        end
        if (sensorOut.exposureActive === 1'b1) begin
            curLen <= curLen + 1;
        end else if (curLen != 0) begin
            chk("readoutStart", 1, sensorOut.readoutStart);
            lastLen <= curLen;
            curLen <= 0;
            expEnd <= cyc;
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge clk_sys);
        apbReq <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        @(posedge clk_sys);
        // Only the bench ceiling ends a stalled access.
        while (apbRsp.pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        r = apbRsp.prdata;
        lastErr = apbRsp.pslverr;
        apbReq <= '0;
    endtask
    task automatic soft_case(input logic [31:0] fm, rc, tm, ar, input int u, st);
        int f0, t0, n;
        logic [31:0] r;
        apb(1'b1, OFF_FORMAT, fm, r);
        apb(1'b1, OFF_RATE_CTRL, rc, r);
        apb(1'b1, OFF_TRIGGER_MODE, tm, r);
        apb(1'b1, OFF_CAPTURE_ARM, ar, r);
        f0 = fsCount;
        apb(1'b1, OFF_SOFT_TRIGGER, 32'h1, r);
        t0 = cyc;
        repeat (2) @(posedge clk_sys);
        chk("softStart", st, fsCount - f0);
        if (st == 1) begin
            chk("softDelay", t0 + 1, fsCyc);
        end
        apb(1'b1, OFF_SOFT_TRIGGER, 32'h1, r);
        n = 0;
        do begin
            apb(1'b0, OFF_SOFT_TRIGGER, 32'h0, r);
            n++;
        end while (r[0] === 1'b1 && n < 1000);
        chk("softClear", 0, r[0]);
        chk("pace", 1, u == 0 || (cyc - t0 >= u * 500 && cyc - t0 <= u * 500 + 8));
        chk("starts", st, fsCount - f0);
        if (st == 1) begin
            chk("softLen", 1, lastLen >= 500 && lastLen <= 501);
        end
        $display("test soft %0h %0h %0h %0h done", fm, rc, tm, ar);
    endtask
    task automatic ext_case(input logic [2:0] p, input logic pl, md, input int w, lo, hi);
        int f0, t;
        logic [31:0] r;
        // Disable first so the idle level change cannot look like an edge.
        apb(1'b1, OFF_TRIGGER_MODE, 32'h0, r);
        ext <= {2{~pl}};
        apb(1'b1, OFF_TRIGGER_MODE, {25'h0, p, 1'b0, md, pl, 1'b1}, r);
        repeat (8) @(posedge clk_sys);
        f0 = fsCount;
        ext[~p[0]] <= pl;
        repeat (w) @(posedge clk_sys);
        ext[~p[0]] <= ~pl;
        repeat (8) @(posedge clk_sys);
        chk("otherPort", f0, fsCount);
        ext[p[0]] <= pl;
        t = cyc;
        repeat (w) @(posedge clk_sys);
        ext[p[0]] <= ~pl;
        repeat (8) @(posedge clk_sys);
        while ((curLen != 0 || sensorOut.exposureActive !== 1'b0) && cyc < t + 4000) begin
            @(posedge clk_sys);
        end
        chk("extStart", f0 + 1, fsCount);
        chk("syncDelay", 1, fsCyc - t >= 4 && fsCyc - t <= 6);
        chk("extLen", 1, lastLen >= lo && lastLen <= hi);
        chk("ready", 1, sensorOut.triggerReady);
        $display("test ext %0d %0d %0d %0d done", p, pl, md, w);
    endtask
    initial begin
        logic [31:0] r;
        int w;
        rst = 1'b1;
        apbReq = '0;
        ext = 2'b00;
        maxPeriodUnits = 16'h0002;
        readCycles = 16'h000a;
        void'($urandom(67782));
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, OFF_SHUTTER, 32'h0, r);
        chk("shutterRst", 32'(SHUTTER_RST), r);
        apb(1'b0, OFF_TRIGGER_MODE, 32'h0, r);
        chk("modeRst", TRIGGER_MODE_RST, r);
        apb(1'b0, 8'h1c, 32'h0, r);
        chk("unmapped", 32'h1, {31'h0, lastErr});
        $display("test registers done");
        apb(1'b1, OFF_SHUTTER, 32'h1, r);
        soft_case(32'h0003_0000, 32'h0, 32'h71, 32'h1, 3, 1);
        soft_case(32'h0001_0001, 32'h0, 32'h71, 32'h1, 2, 1);
        soft_case(32'h0003_0002, 32'h0, 32'h71, 32'h1, 3, 1);
        soft_case(32'h0001_0007, 32'h3, 32'h71, 32'h1, 2, 1);
        soft_case(32'h0001_0007, 32'h8000_0003, 32'h71, 32'h1, 3, 1);
        soft_case(32'h0001_0007, 32'h8000_0001, 32'h71, 32'h1, 2, 1);
        soft_case(32'h0001_0007, 32'h0, 32'h71, 32'h0, 0, 0);
        soft_case(32'h0001_0007, 32'h0, 32'h70, 32'h1, 0, 0);
        soft_case(32'h0001_0007, 32'h0, 32'h01, 32'h1, 0, 0);
        maxPeriodUnits <= 16'h0001;
        for (int i = 0; i < 4; i++) begin
            w = 3 + $urandom_range(20);
            ext_case(3'(i / 2), i[0], 1'b0, w, 500, 501);
            w = 600 + $urandom_range(200);
            ext_case(3'(i / 2), i[0], 1'b1, w, w - 2, w + 2);
        end
        ext_case(3'h0, 1'b1, 1'b1, 100, 500, 503);
        readCycles <= 16'h05dc;
        ext_case(3'h1, 1'b1, 1'b0, 5, 500, 501);
        ext_case(3'h1, 1'b1, 1'b1, 600, 0, 5000);
        chk("extended", 1, expEnd - busyFall >= 0 && expEnd - busyFall <= 3);
        // Long enough that the next level pulse begins inside this readout.
        readCycles <= 16'h0400;
        ext_case(3'h0, 1'b0, 1'b0, 5, 500, 501);
        ext_case(3'h0, 1'b0, 1'b1, 800, 798, 802);
        complete_run();
    end
endmodule
`default_nettype wire
